// >>> src/efcu_flow_ctrl.sv
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
// --------
// Summary of operation
// [RQ1] end without notify: no interrupt, no status
// [RQ2] end with notify: PC zero, interrupt, status
// [RQ3] reading status clears interrupt and releases pin
// [RQ4] end without reset: PC zero, hold, PWM kept
// [RQ5] end with reset: clear mapped PWM only
// [RQ6] end with reset: clear own master fade
// [RQ7] send sixteen ticks, wait at least sixteen
// [RQ8] triggers latched until a wait consumes them
// [RQ9] wait stalls until all selected triggers seen
// [RQ10] external trigger must stay low two ticks
// [RQ11] external trigger out low three ticks
// [RQ12] external trigger line is active low
// [RQ13] own external trigger is never received
// [RQ14] external send completes before external wait
// [RQ15] wait field bits 7,8,9 engines, 12 external
// [RQ16] send field bits 1,2,3 engines, 6 external
// [RQ17] four compare jumps: ne, ge, below, same
// [RQ18] true jumps forward skip count, else next
// [RQ19] five-bit skip count, zero has no effect
// [RQ20] operand select: A, B, global, D register; code reads the ALT register as D while ctrl_dsel_r is set
// [RQ21] end takes sixteen engine ticks
// [RQ22] comparisons are unsigned
// --------
module efcu_flow_ctrl #(
    parameter int TICK_DIV = efcu_pkg::TICK_DIV
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic INT_N,
    input wire logic TRIG_I,
    output logic TRIG_O,
    output logic TRIG_OE_N
);
    if (TICK_DIV < 2 || TICK_DIV > 4095) begin : g_chk
        $error("efcu_flow_ctrl: TICK_DIV out of range");
    end

    // --------
    // helpers
    // --------
    function automatic logic [7:0] pick_operand(input logic [1:0] s, input logic [7:0] a,
                                                input logic [7:0] b, input logic [7:0] c,
                                                input logic [7:0] d);
        case (s)
            2'h0: pick_operand = a;
            2'h1: pick_operand = b;
            2'h2: pick_operand = c;
            default: pick_operand = d;
        endcase
    endfunction : pick_operand

    // operands are unsigned bytes
    function automatic logic cond_true(input logic [1:0] c, input logic [7:0] x,
                                       input logic [7:0] y);
        case (c)
            efcu_pkg::CND_NE: cond_true = x != y;
            efcu_pkg::CND_GE: cond_true = x >= y;
            efcu_pkg::CND_SKIP_IF_BELOW: cond_true = x < y;
            efcu_pkg::CND_SKIP_IF_SAME: cond_true = x == y;
            default: cond_true = 1'b0;
        endcase
    endfunction : cond_true

    function automatic logic [3:0] wait_mask(input logic [15:0] w);
        wait_mask = {w[efcu_pkg::WAIT_EXT_BIT], w[efcu_pkg::WAIT_LSB +: 3]};
    endfunction : wait_mask

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            lane_merge[8*i +: 8] = sel[i] ? d[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : lane_merge

    // --------
    // state
    // --------
    efcu_pkg::efcu_state_type st_r [3];
    efcu_pkg::efcu_state_type st_nxt [3];
    logic [3:0] cnt_r [3];
    logic [3:0] cnt_nxt [3];
    logic [6:0] pc_r [3];
    logic [6:0] pc_nxt [3];
    logic [15:0] instr_r [3];
    logic [3:0] lat_r [3];
    logic [3:0] lat_nxt [3];
    logic [3:0] lat_set [3];
    logic [3:0] lat_clr [3];
    logic [7:0] var_a_r [3];
    logic [7:0] var_b_r [3];
    logic [7:0] fade_r [3];
    logic [7:0] pwm_r [9];
    logic [17:0] map_r;
    logic [7:0] var_c_r, var_d_r, var_alt_r, opd, op1, op2;
    logic ctrl_dsel_r;
    logic [2:0] int_r, int_nxt, int_set, fade_clr, done, issue;
    logic [11:0] div_r;
    logic tick, ack_r, int_n_r, ext_send, ext_recv, wb_req, wr, wr8, rd_status;
    logic ext_hold_r, ext_low_r;
    logic [31:0] dat_o_r, rd_data;
    logic [7:0] idx;
    logic [3:0] wm;
    logic [15:0] iw;

    // --------
    // bus decode
    // --------
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
    assign idx = WB_ADR_I[9:2];
    assign wr = wb_req & WB_WE_I;
    assign wr8 = wr & WB_SEL_I[0];
    assign rd_status = wb_req & ~WB_WE_I & idx == efcu_pkg::REG_STATUS; // RQ3
    assign tick = div_r == 12'(TICK_DIV - 1);
    assign opd = ctrl_dsel_r ? var_alt_r : var_d_r;

    for (genvar e = 0; e < 3; e++) begin : g_issue
        // a new instruction is refused while the engine is busy
        assign issue[e] = wr && WB_SEL_I[1:0] == 2'h3 && st_r[e] == efcu_pkg::ST_IDLE
                          && idx == efcu_pkg::REG_INSTR0 + 8'(e);
    end

    always_comb begin
        rd_data = 32'h0;
        case (idx)
            efcu_pkg::REG_STATUS: begin
                for (int e = 0; e < 3; e++) begin
                    rd_data[3 + e] = st_r[e] != efcu_pkg::ST_IDLE;
                end
                rd_data[2:0] = int_r;
            end
            efcu_pkg::REG_VAR_D: rd_data[7:0] = var_d_r;
            efcu_pkg::REG_VAR_ALT: rd_data[7:0] = var_alt_r;
            efcu_pkg::REG_VAR_C: rd_data[7:0] = var_c_r;
            efcu_pkg::REG_CTRL: rd_data[efcu_pkg::CTRL_DSEL_BIT] = ctrl_dsel_r;
            efcu_pkg::REG_MAP: rd_data[17:0] = map_r;
            efcu_pkg::REG_TRGLAT: rd_data[11:0] = {lat_r[2], lat_r[1], lat_r[0]};
            default: rd_data = 32'h0;
        endcase
        for (int e = 0; e < 3; e++) begin
            if (idx == efcu_pkg::REG_PC0 + 8'(e)) rd_data[6:0] = pc_r[e];
            if (idx == efcu_pkg::REG_FADE0 + 8'(e)) rd_data[7:0] = fade_r[e];
            if (idx == efcu_pkg::REG_INSTR0 + 8'(e)) rd_data[15:0] = instr_r[e];
            if (idx == efcu_pkg::REG_VARA0 + 8'(e)) rd_data[7:0] = var_a_r[e];
            if (idx == efcu_pkg::REG_VARB0 + 8'(e)) rd_data[7:0] = var_b_r[e];
        end
        for (int i = 0; i < 9; i++) begin
            if (idx == efcu_pkg::REG_PWM0 + 8'(i)) rd_data[7:0] = pwm_r[i];
        end
    end

    // --------
    // engine sequencing
    // --------
    always_comb begin
        ext_send = 1'b0;
        wm = 4'h0;
        iw = 16'h0;
        op1 = 8'h0;
        op2 = 8'h0;
        for (int e = 0; e < 3; e++) begin
            done[e] = tick && st_r[e] == efcu_pkg::ST_EXEC && cnt_r[e] == efcu_pkg::EXEC_LAST;
            lat_set[e] = {ext_recv, 3'h0}; // RQ8
        end
        for (int e = 0; e < 3; e++) begin
            iw = instr_r[e];
            if (done[e] && iw[efcu_pkg::OPC_LSB +: 3] == efcu_pkg::OPC_SYNC) begin
                for (int k = 0; k < 3; k++) begin
                    if (iw[efcu_pkg::SEND_LSB + k]) lat_set[k][e] = 1'b1; // RQ16 RQ8
                end
                if (iw[efcu_pkg::SEND_EXT_BIT]) ext_send = 1'b1; // RQ16
            end
        end
        for (int e = 0; e < 3; e++) begin
            iw = instr_r[e];
            wm = wait_mask(iw); // RQ15
            st_nxt[e] = st_r[e];
            cnt_nxt[e] = cnt_r[e];
            pc_nxt[e] = pc_r[e];
            lat_clr[e] = 4'h0;
            int_set[e] = 1'b0;
            fade_clr[e] = 1'b0;
            op1 = pick_operand(iw[efcu_pkg::OPA_LSB +: 2], var_a_r[e], var_b_r[e], var_c_r,
                               opd); // RQ20
            op2 = pick_operand(iw[efcu_pkg::OPB_LSB +: 2], var_a_r[e], var_b_r[e], var_c_r,
                               opd); // RQ20
            case (st_r[e])
                efcu_pkg::ST_IDLE: begin
                    if (issue[e]) begin
                        st_nxt[e] = efcu_pkg::ST_EXEC;
                        cnt_nxt[e] = 4'h0;
                    end
                end
                efcu_pkg::ST_EXEC: begin
                    if (tick) cnt_nxt[e] = cnt_r[e] + 4'h1; // RQ7 RQ21
                    if (done[e]) begin
                        st_nxt[e] = efcu_pkg::ST_IDLE;
                        pc_nxt[e] = pc_r[e] + 7'h1; // RQ18
                        case (iw[efcu_pkg::OPC_LSB +: 3])
                            efcu_pkg::OPC_JUMP: begin
                                // a zero skip lands on the next instruction
                                if (cond_true(iw[efcu_pkg::COND_LSB +: 2], op1, op2)) begin
                                    pc_nxt[e] = pc_r[e] + 7'(iw[efcu_pkg::SKIP_LSB +: 5])
                                                + 7'h1; // RQ17 RQ18 RQ19 RQ22
                                end
                            end
                            efcu_pkg::OPC_END: begin
                                pc_nxt[e] = 7'h0; // RQ2 RQ4 RQ5
                                int_set[e] = iw[efcu_pkg::END_INT_BIT]; // RQ1 RQ2
                                fade_clr[e] = iw[efcu_pkg::END_RST_BIT]; // RQ4 RQ5 RQ6
                            end
                            efcu_pkg::OPC_SYNC: begin
                                // a pin wait holds off until the own pulse ends
                                if (wm != 4'h0) st_nxt[e] = efcu_pkg::ST_WAIT; // RQ7 RQ14
                            end
                            default: ;
                        endcase
                    end
                end
                efcu_pkg::ST_WAIT: begin
                    if ((lat_r[e] & wm) == wm && !(wm[3] && ext_hold_r)) begin // RQ9 RQ14
                        lat_clr[e] = wm; // RQ8
                        pc_nxt[e] = pc_r[e] + 7'h1;
                        st_nxt[e] = efcu_pkg::ST_IDLE;
                    end
                end
                default: st_nxt[e] = efcu_pkg::ST_IDLE;
            endcase
            // a trigger arriving as the wait consumes it is kept
            lat_nxt[e] = (lat_r[e] & ~lat_clr[e]) | lat_set[e];
        end
    end

    // set wins over the clear-on-read
    assign int_nxt = (int_r & ~{3{rd_status}}) | int_set; // RQ2 RQ3

    // --------
    // registers
    // --------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            div_r <= 12'h0;
            ack_r <= 1'b0;
            dat_o_r <= 32'h0;
            int_r <= 3'h0;
            int_n_r <= 1'b1;
            ext_hold_r <= 1'b0;
            ext_low_r <= 1'b0;
        end else if (CE) begin
            div_r <= tick ? 12'h0 : div_r + 12'h1;
            ack_r <= wb_req;
            dat_o_r <= (wb_req && !WB_WE_I) ? rd_data : 32'h0;
            int_r <= int_nxt;
            int_n_r <= ~|int_nxt; // RQ2 RQ3
            // own pulse must go out and end first
            ext_hold_r <= ext_send | (ext_hold_r & ~(ext_low_r & TRIG_OE_N)); // RQ14
            ext_low_r <= ext_hold_r & (ext_low_r | ~TRIG_OE_N);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int e = 0; e < 3; e++) begin
                st_r[e] <= efcu_pkg::ST_IDLE;
                cnt_r[e] <= 4'h0;
                pc_r[e] <= 7'h0;
                instr_r[e] <= 16'h0;
                lat_r[e] <= 4'h0;
            end
        end else if (CE) begin
            for (int e = 0; e < 3; e++) begin
                st_r[e] <= st_nxt[e];
                cnt_r[e] <= cnt_nxt[e];
                pc_r[e] <= pc_nxt[e];
                lat_r[e] <= lat_nxt[e];
                if (issue[e]) instr_r[e] <= WB_DAT_I[15:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            var_c_r <= 8'h0;
            var_d_r <= 8'h0;
            var_alt_r <= 8'h0;
            ctrl_dsel_r <= 1'b0;
            map_r <= 18'h0;
            for (int e = 0; e < 3; e++) begin
                var_a_r[e] <= 8'h0;
                var_b_r[e] <= 8'h0;
                fade_r[e] <= 8'h0;
            end
        end else if (CE) begin
            if (wr8 && idx == efcu_pkg::REG_VAR_C) var_c_r <= WB_DAT_I[7:0];
            if (wr8 && idx == efcu_pkg::REG_VAR_D) var_d_r <= WB_DAT_I[7:0];
            if (wr8 && idx == efcu_pkg::REG_VAR_ALT) var_alt_r <= WB_DAT_I[7:0];
            if (wr8 && idx == efcu_pkg::REG_CTRL) begin
                ctrl_dsel_r <= WB_DAT_I[efcu_pkg::CTRL_DSEL_BIT];
            end
            if (wr && idx == efcu_pkg::REG_MAP) begin
                map_r <= 18'(lane_merge(32'(map_r), WB_DAT_I, WB_SEL_I));
            end
            for (int e = 0; e < 3; e++) begin
                if (wr8 && idx == efcu_pkg::REG_VARA0 + 8'(e)) var_a_r[e] <= WB_DAT_I[7:0];
                if (wr8 && idx == efcu_pkg::REG_VARB0 + 8'(e)) var_b_r[e] <= WB_DAT_I[7:0];
                if (fade_clr[e]) begin
                    fade_r[e] <= efcu_pkg::FADE_CLEAR; // RQ6
                end else if (wr8 && idx == efcu_pkg::REG_FADE0 + 8'(e)) begin
                    fade_r[e] <= WB_DAT_I[7:0];
                end
            end
        end
    end

    // map field per driver: 0 unmapped, 1..3 engine number
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 9; i++) begin
                pwm_r[i] <= 8'h0;
            end
        end else if (CE) begin
            for (int i = 0; i < 9; i++) begin
                if (map_r[2*i +: 2] != 2'h0 && fade_clr[map_r[2*i +: 2] - 2'h1]) begin
                    pwm_r[i] <= efcu_pkg::PWM_CLEAR; // RQ5
                end else if (wr8 && idx == efcu_pkg::REG_PWM0 + 8'(i)) begin
                    pwm_r[i] <= WB_DAT_I[7:0];
                end
            end
        end
    end

    // --------
    // external trigger pin
    // --------
    efcu_ext_trig u_ext_trig (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CE),
        .tick(tick),
        .send(ext_send),
        .pin_i(TRIG_I),
        .pin_o(TRIG_O),
        .pin_oe_n(TRIG_OE_N),
        .recv(ext_recv)
    );

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_o_r;
    assign INT_N = int_n_r;
endmodule : efcu_flow_ctrl

// >>> src/efcu_pkg.sv
// --------
// engine flow control constants
// --------
package efcu_pkg;

    // --------
    // register indices (byte address is four times the index)
    // --------
    localparam logic [7:0] REG_PC0 = 8'h37;
    localparam logic [7:0] REG_STATUS = 8'h3a;
    localparam logic [7:0] REG_VAR_D = 8'h3c;
    localparam logic [7:0] REG_VAR_ALT = 8'h42;
    localparam logic [7:0] REG_FADE0 = 8'h48;
    localparam logic [7:0] REG_INSTR0 = 8'h50;
    localparam logic [7:0] REG_VAR_C = 8'h53;
    localparam logic [7:0] REG_VARA0 = 8'h54;
    localparam logic [7:0] REG_VARB0 = 8'h57;
    localparam logic [7:0] REG_CTRL = 8'h5b;
    localparam logic [7:0] REG_MAP = 8'h5c;
    localparam logic [7:0] REG_TRGLAT = 8'h5d;
    localparam logic [7:0] REG_PWM0 = 8'h60;
    localparam int NUM_ENG = 3;
    localparam int NUM_DRV = 9;
    localparam int CTRL_DSEL_BIT = 0;
    localparam logic [7:0] PWM_CLEAR = 8'h00;
    localparam logic [7:0] FADE_CLEAR = 8'h00;

    // --------
    // instruction word layout
    // --------
    localparam logic [2:0] OPC_JUMP = 3'h4;
    localparam logic [2:0] OPC_END = 3'h6;
    localparam logic [2:0] OPC_SYNC = 3'h7;
    localparam int OPC_LSB = 13;
    localparam int COND_LSB = 11;
    localparam int SKIP_LSB = 4;
    localparam int OPA_LSB = 2;
    localparam int OPB_LSB = 0;
    localparam int END_INT_BIT = 12;
    localparam int END_RST_BIT = 11;
    localparam int WAIT_LSB = 7;
    localparam int WAIT_EXT_BIT = 12;
    localparam int SEND_LSB = 1;
    localparam int SEND_EXT_BIT = 6;
    localparam logic [1:0] CND_NE = 2'h0;
    localparam logic [1:0] CND_GE = 2'h1;
    localparam logic [1:0] CND_SKIP_IF_BELOW = 2'h2;
    localparam logic [1:0] CND_SKIP_IF_SAME = 2'h3;

    // --------
    // timing
    // --------
    localparam int CORE_CLK_HZ = 125000000;
    localparam int ENG_CLK_HZ = 32000;
    localparam int TICK_DIV = CORE_CLK_HZ / ENG_CLK_HZ;
    localparam int INSTR_TICKS = 16;
    localparam logic [3:0] EXEC_LAST = 4'(INSTR_TICKS - 1);
    localparam int EXT_MIN_LOW_TICKS = 2;
    localparam int EXT_PULSE_TICKS = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} efcu_state_type;

endpackage : efcu_pkg

// >>> src/efcu_ext_trig.sv
`timescale 1ns/100ps
// --------
// external trigger pin: send pulse, masked receive
// --------
module efcu_ext_trig #(
    parameter int PULSE_TICKS = efcu_pkg::EXT_PULSE_TICKS,
    parameter int MIN_LOW = efcu_pkg::EXT_MIN_LOW_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic send,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n,
    output logic recv
);
    if (PULSE_TICKS < 1 || PULSE_TICKS > 15 || MIN_LOW < 1 || MIN_LOW > 15) begin : g_chk
        $error("efcu_ext_trig: tick counts out of range");
    end

    logic sync1_r, sync2_r, pend_r, mask_r, recv_r, oe_n_r, drive;
    logic [3:0] drv_cnt_r, drv_nxt, low_cnt_r;

    // pulse starts on a tick so the low time is whole engine periods
    assign drv_nxt = (tick && pend_r) ? 4'(PULSE_TICKS) :
                     (tick && drv_cnt_r != 4'h0) ? drv_cnt_r - 4'h1 : drv_cnt_r; // RQ11
    assign drive = drv_nxt != 4'h0;
    assign pin_o = 1'b0; // RQ12
    assign pin_oe_n = oe_n_r;
    assign recv = recv_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            pend_r <= 1'b0;
            drv_cnt_r <= 4'h0;
            oe_n_r <= 1'b1;
            mask_r <= 1'b0;
            low_cnt_r <= 4'h0;
            recv_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            pend_r <= send | (pend_r & ~tick);
            drv_cnt_r <= drv_nxt;
            oe_n_r <= ~drive;
            // own pulse stays masked until the line is seen high again
            mask_r <= drive | (mask_r & ~sync2_r); // RQ13
            recv_r <= 1'b0;
            if (sync2_r || mask_r) begin
                low_cnt_r <= 4'h0;
            end else if (tick && low_cnt_r != 4'(MIN_LOW)) begin
                low_cnt_r <= low_cnt_r + 4'h1;
                recv_r <= (low_cnt_r == 4'(MIN_LOW - 1)); // RQ10 RQ12
            end
        end
    end
endmodule : efcu_ext_trig

// >>> testbench/efcu_flow_ctrl_assertions.sv
`timescale 1ns/100ps
// --------
// bus, interrupt and trigger pin checks
// --------
module efcu_flow_ctrl_chk #(
    parameter int TICK_DIV = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [9:0] WB_ADR_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic INT_N,
    input wire logic TRIG_O,
    input wire logic TRIG_OE_N
);
    localparam int PULSE_CYC = 3 * TICK_DIV;
    logic [15:0] low_cnt_r;
    wire req = WB_CYC_I && WB_STB_I;
    wire status_rd = req && !WB_WE_I && WB_ADR_I[9:2] == efcu_pkg::REG_STATUS;
    // counts only enabled cycles, the pulse is measured in engine ticks
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            low_cnt_r <= 16'h0;
        else if (TRIG_OE_N)
            low_cnt_r <= 16'h0;
        else if (CE)
            low_cnt_r <= low_cnt_r + 16'h1;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_take; req && !WB_ACK_O && CE; endsequence
    sequence s_status_ack; status_rd ##1 WB_ACK_O; endsequence
    property p_ack_resp; s_take |=> WB_ACK_O; endproperty
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    property p_ack_cause; $rose(WB_ACK_O) |-> $past(req); endproperty
    property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
    property p_trig_level; TRIG_O == 1'b0; endproperty
    property p_pulse_min; $fell(TRIG_OE_N) |-> !TRIG_OE_N [*8]; endproperty
    property p_pulse_len; $rose(TRIG_OE_N) |-> low_cnt_r == PULSE_CYC; endproperty
    property p_int_clear; s_status_ack |-> ##[1:2] INT_N; endproperty
    property p_int_hold; !INT_N && !WB_CYC_I && !$past(WB_CYC_I) |=> !INT_N; endproperty
    property p_rst_idle; disable iff (1'b0) RST |-> INT_N && TRIG_OE_N && !WB_ACK_O; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    a_trig_level: assert property (p_trig_level) else $error("trigger drives high");
    a_pulse_min: assert property (p_pulse_min) else $error("trigger pulse too short");
    a_pulse_len: assert property (p_pulse_len) else $error("trigger pulse length");
    a_int_clear: assert property (p_int_clear) else $error("status read kept int");
    a_int_hold: assert property (p_int_hold) else $error("int released unread");
    a_rst_idle: assert property (p_rst_idle) else $error("active in reset");
endmodule : efcu_flow_ctrl_chk

bind efcu_flow_ctrl efcu_flow_ctrl_chk #(.TICK_DIV(TICK_DIV)) u_efcu_flow_ctrl_chk (
    .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .WB_ADR_I(WB_ADR_I), .WB_WE_I(WB_WE_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .INT_N(INT_N), .TRIG_O(TRIG_O), .TRIG_OE_N(TRIG_OE_N));

// >>> testbench/efcu_peer_model.sv
`timescale 1ns/100ps
// --------
// peer device on the shared trigger line
// --------
module efcu_peer_model #(
    parameter int TICK_DIV = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic dut_o,
    input wire logic dut_oe_n,
    output logic line
);
    logic [7:0] low_cnt_r;
    // the shortest legal pulse, no margin given
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt_r <= 8'h0;
        else if (fire)
            low_cnt_r <= 8'(2 * TICK_DIV);
        else if (low_cnt_r != 8'h0)
            low_cnt_r <= low_cnt_r - 8'h1;
    end
    // pull-up when nobody pulls
    assign line = (dut_oe_n ? 1'b1 : dut_o) & (low_cnt_r == 8'h0);
endmodule : efcu_peer_model

// >>> testbench/efcu_flow_ctrl_test.sv
`timescale 1ns/100ps
// --------
// flow control regression
// --------
module efcu_flow_ctrl_test;
    localparam int TD = 8;
    localparam int RUN = 17 * TD + 4;
    localparam logic [7:0] VI [3] = '{8'h54, 8'h57, 8'h53};
    localparam logic [15:0] ENDW [3] = '{16'hc000, 16'hc800, 16'hd000};
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
    logic [9:0] adr = 10'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] q, dat_o;
    logic ack, int_n, trig_o, trig_oe_n, line;
    logic [15:0] lfsr = 16'h1dc5;
    logic [7:0] v [4];
    logic [7:0] p0, p1, f1, f2;
    logic [1:0] c, o1, o2;
    logic [4:0] s;
    logic [6:0] pc;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    always #4 clk = ~clk;
    efcu_flow_ctrl #(.TICK_DIV(TD)) u_efcu_flow_ctrl (.CORE_CLK(clk), .RST(rst), .CE(1'b1),
        .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .INT_N(int_n), .TRIG_I(line),
        .TRIG_O(trig_o), .TRIG_OE_N(trig_oe_n));
    efcu_peer_model #(.TICK_DIV(TD)) u_efcu_peer_model (.clk(clk), .rst(rst), .fire(fire),
        .dut_o(trig_o), .dut_oe_n(trig_oe_n), .line(line));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    function automatic logic [6:0] jump_pc(logic [6:0] p, logic [7:0] x, logic [7:0] y);
        logic t;
        case (c)
            2'h0: t = x != y;
            2'h1: t = x >= y;
            2'h2: t = x < y;
            default: t = x == y;
        endcase
        return t ? p + 7'(s) + 7'h1 : p + 7'h1;
    endfunction : jump_pc
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic wb(logic w, logic [7:0] i, logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        if (ack !== 1'b1) begin
            chk("bus ack", 0, 1);
            report_and_stop();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(logic [7:0] i, logic [31:0] e, string nm);
        wb(1'b0, i, 32'h0);
        chk(nm, q, e);
    endtask : rd
    task automatic run(logic [7:0] e, logic [15:0] w);
        wb(1'b1, 8'h50 + e, {16'h0, w});
        repeat (RUN) @(posedge clk);
    endtask : run
    // bounded wait for the trigger enable to reach a level
    task automatic wait_oe(logic lv);
        n = 0;
        while (trig_oe_n !== lv && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (trig_oe_n !== lv) begin
            chk("trigger wait", 0, 1);
            report_and_stop();
        end
    endtask : wait_oe
    initial begin
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("int_n reset", int_n, 1);
        chk("oe_n reset", trig_oe_n, 1);
        rd(8'h40, 0, "unmapped");
        for (int k = 0; k < 12; k++) begin
            for (int j = 0; j < 4; j++) v[j] = rnd();
            if (k % 2 == 1) v[1] = v[0];
            for (int j = 0; j < 3; j++) wb(1'b1, VI[j], 32'(v[j]));
            if (k == 8) wb(1'b1, 8'h5b, 32'h1);
            wb(1'b1, (k < 8) ? 8'h3c : 8'h42, 32'(v[3]));
            c = 2'(k);
            s = (k == 2) ? 5'h0 : 5'(rnd());
            o1 = (k < 4) ? 2'h0 : (k > 7) ? 2'h3 : 2'(rnd());
            o2 = (k < 4) ? 2'h1 : 2'(rnd());
            wb(1'b0, 8'h37, 32'h0);
            pc = q[6:0];
            run(8'h0, {3'b100, c, 2'b00, s, o1, o2});
            rd(8'h37, 32'(jump_pc(pc, v[o1], v[o2])), "pc jump");
        end
        $display("jump test done");
        wb(1'b1, 8'h5c, 32'h1);
        for (int k = 0; k < 3; k++) begin
            p0 = rnd();
            p1 = rnd();
            f1 = rnd();
            f2 = rnd();
            wb(1'b1, 8'h60, 32'(p0));
            wb(1'b1, 8'h61, 32'(p1));
            wb(1'b1, 8'h48, 32'(f1));
            wb(1'b1, 8'h49, 32'(f2));
            run(8'h0, ENDW[k]);
            chk("int_n end", int_n, 32'(!ENDW[k][12]));
            rd(8'h3a, 32'(ENDW[k][12]), "status");
            repeat (3) @(posedge clk);
            chk("int_n cleared", int_n, 1);
            rd(8'h37, 0, "pc end");
            rd(8'h60, 32'(ENDW[k][11] ? 8'h0 : p0), "pwm mapped");
            rd(8'h61, 32'(p1), "pwm unmapped");
            rd(8'h48, 32'(ENDW[k][11] ? 8'h0 : f1), "fade own");
            rd(8'h49, 32'(f2), "fade other");
        end
        $display("end test done");
        wb(1'b1, 8'h51, 32'he280);
        run(8'h0, 16'he004);
        rd(8'h3a, 32'h10, "wait stalls");
        run(8'h2, 16'he004);
        repeat (2 * TD) @(posedge clk);
        rd(8'h3a, 32'h0, "wait released");
        rd(8'h5d, 32'h0, "latches consumed");
        $display("engine trigger test done");
        wb(1'b1, 8'h50, 32'hf040);
        wait_oe(1'b0);
        chk("send delay", 32'(n >= 16 * TD - 4 && n <= 17 * TD + 4), 1);
        wait_oe(1'b1);
        repeat (4 * TD) @(posedge clk);
        rd(8'h3a, 32'h08, "own pulse masked");
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (4 * TD) @(posedge clk);
        rd(8'h5d, 32'h880, "external latched");
        rd(8'h3a, 32'h0, "external wait done");
        $display("external trigger test done");
        report_and_stop();
    end
endmodule : efcu_flow_ctrl_test
